// file: dpw_buf2.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Two-entry buffer between fetch and port
// ----------------------------------------
module dpw_buf2
#(
	parameter int WIDTH = 24
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	typedef struct packed
	{
		logic [1:0][WIDTH-1:0] mem;
		logic wr;
		logic rd;
		logic [1:0] cnt;
	} dpw_buf_t;

	dpw_buf_t st;
	dpw_buf_t next_st;
	logic push;
	logic pop;

	// Handshakes from fill level
	assign in_ready = (st.cnt != 2'h2);
	assign out_valid = (st.cnt != 2'h0);
	assign out_data = st.mem[st.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next state
	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = ~st.wr;
		end
		if (pop)
			next_st.rd = ~st.rd;
		if (push && !pop)
			next_st.cnt = st.cnt + 2'h1;
		else if (pop && !push)
			next_st.cnt = st.cnt - 2'h1;
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	// Fill level never exceeds two
	property p_cnt_max;
		@(posedge ref_clk) disable iff (sys_rst)
		st.cnt <= 2'h2;
	endproperty
	a_cnt_max: assert property (p_cnt_max)
		else $error("buffer fill above two");
endmodule
`default_nettype wire

// file: dpw_defs.svh
`ifndef DPW_DEFS_SVH
`define DPW_DEFS_SVH
// ----------------------------------------
// Output port decode
// ----------------------------------------
`define DPW_PORT_ADDR 16'h4100
`define DPW_NOOP_IDX 3'h7
`define DPW_NUM_OUT 7
// ----------------------------------------
// Pattern buffer paging
// ----------------------------------------
`define DPW_PAGE_BITS 8
`define DPW_PAGE_ZERO 8'h00
// ----------------------------------------
// Serial clock timing
// ----------------------------------------
`define DPW_CLK_HZ 50000000
`define DPW_BASE_HZ 19200
`define DPW_MULT_2 2
`define DPW_MULT_4 4
`define DPW_MULT_8 8
`define DPW_ACC_W 27
`endif

// file: dpw_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Pattern memory model
// ----------------------------------------
module dpw_mem_model
(
	// Clock
	input wire logic ref_clk,
	// Read port
	input wire logic mem_rd,
	input wire logic [19:0] mem_addr,
	output logic [7:0] mem_data
);
	logic [7:0] mem [0:4095];
	logic [7:0] last = 8'h5A;
	// Keep the last byte read, shown inverted when idle
	always @(posedge ref_clk)
		if (mem_rd) last <= mem[mem_addr[11:0]];
	// Byte stands during the read cycle, else scrambled
	assign mem_data = mem_rd ? mem[mem_addr[11:0]] : ~last;
endmodule
`default_nettype wire

// file: dpw_pkg.sv
package dpw_pkg;
	// Serial clock multiplier of the base rate
	typedef enum logic [1:0] {DPW_X2, DPW_X4, DPW_X8} dpw_rate_t;
endpackage

// file: dpw_top.sv
// Notes on behaviour
// RULE1: Byte low nibble selects output 0 to 6
// RULE2: Bit 0 is new level of output
// RULE3: 0x01/0x00 drive output 0, 0x03/0x02 output 1
// RULE4: Byte 0x0E changes no output
// RULE5: Pattern bytes go to port 0x4100
// RULE6: One byte transfer per request falling edge
// RULE7: Serial clock output feeds transfer request
// RULE8: Each step holds one byte per channel
// RULE9: Steps repeat per period, setting duty
// RULE10: Exhausted count stops transfers, no reload
// RULE11: Refresh rewinds counter and source address
// RULE12: Rewind stays in phase with waveform
// RULE13: Refresh often enough that count never empties
// RULE14: Serial clock is 19.2 kHz times 2, 4, 8
// RULE15: Buffer starts on 256-byte page, sized in pages
// RULE16: Separate overflow area counted in pages
// RULE17: Default transfer clock 76,800 Hz
// RULE18: Duty change moves only that channel's edges
// RULE19: Second buffer for all-or-none changes
// RULE20: Transfer rate is channels times freq times steps
// RULE21: Outputs hold level between edge bytes
`timescale 1ns/1ns
`default_nettype none
`include "dpw_defs.svh"
module dpw_top
	import dpw_pkg::*;
#(
	parameter int PAGE_W = 12,
	parameter int SIZE_W = 8
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Serial clock and request pin
	input wire dpw_rate_t rate_sel,
	output logic serial_port_clock_out,
	input wire logic dma_channel_request,
	// Transfer control
	input wire logic start,
	input wire logic [PAGE_W-1:0] start_page,
	input wire logic [SIZE_W-1:0] size_pages,
	input wire logic [SIZE_W-1:0] ovf_pages,
	input wire logic [15:0] dest_addr,
	input wire logic rewind,
	input wire logic [PAGE_W+7:0] rewind_addr,
	input wire logic [SIZE_W+8:0] rewind_count,
	output logic running,
	output logic [SIZE_W+8:0] remain,
	output logic done,
	// Pattern memory
	output logic mem_rd,
	output logic [PAGE_W+7:0] mem_addr,
	input wire logic [7:0] mem_data,
	// Output port
	input wire logic port_hold,
	output logic [`DPW_NUM_OUT-1:0] hc_out
);
	localparam int ADDR_W = PAGE_W + 8;
	localparam int CNT_W = SIZE_W + 9;
	localparam logic [`DPW_ACC_W-1:0] CLK_HZ = `DPW_ACC_W'(`DPW_CLK_HZ);

	typedef struct packed
	{
		logic [2:0] sync;
		logic req_lvl;
		logic pend;
		logic fetch;
		logic run;
		logic [ADDR_W-1:0] addr;
		logic [CNT_W-1:0] cnt;
		logic [`DPW_ACC_W-1:0] acc;
		logic sclk;
		logic [`DPW_NUM_OUT-1:0] hc;
		logic done;
	} dpw_state_t;

	dpw_state_t st;
	dpw_state_t next_st;
	logic fall;
	logic wrap;
	logic [`DPW_ACC_W-1:0] inc;
	logic buf_ready;
	logic buf_valid;
	logic [23:0] buf_data;
	logic accept;
	logic hit;
	logic [2:0] sel;
	logic level;

	// Half-period step per cycle for a multiplier
	function automatic logic [`DPW_ACC_W-1:0] rate_inc(dpw_rate_t r);
		int m;
		m = `DPW_MULT_2;
		unique case (r)
			DPW_X2: m = `DPW_MULT_2;
			DPW_X4: m = `DPW_MULT_4;
			DPW_X8: m = `DPW_MULT_8;
			default: m = `DPW_MULT_2;
		endcase
		return `DPW_ACC_W'(2 * `DPW_BASE_HZ * m);
	endfunction

	// Fractional divider and request edge detection
	assign inc = rate_inc(rate_sel); // [RULE14]
	assign wrap = (st.acc + inc) >= CLK_HZ;
	assign fall = (st.sync[1] == st.sync[2]) && !st.sync[2] && st.req_lvl;

	// Port decode of buffered writes
	assign hit = buf_data[23:8] == `DPW_PORT_ADDR; // [RULE5]
	assign sel = buf_data[3:1]; // [RULE1]
	assign level = buf_data[0]; // [RULE2]
	assign accept = buf_valid && !port_hold;

	// Outputs from state
	assign serial_port_clock_out = st.sclk; // [RULE7]
	assign running = st.run;
	assign remain = st.cnt;
	assign done = st.done;
	assign mem_rd = st.fetch;
	assign mem_addr = st.addr;
	assign hc_out = st.hc;

	// Next state
	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.fetch = 1'b0;
		next_st.sync = {st.sync[1:0], dma_channel_request};
		if (st.sync[1] == st.sync[2])
			next_st.req_lvl = st.sync[2];
		// Serial clock toggles on accumulator wrap
		if (wrap)
		begin
			next_st.acc = st.acc + inc - CLK_HZ; // [RULE14]
			next_st.sclk = ~st.sclk;
		end
		else
			next_st.acc = st.acc + inc;
		// Issue a pending fetch; a new edge in that cycle still arms
		if (st.pend && !st.fetch && buf_ready && st.cnt != '0)
		begin
			next_st.pend = 1'b0;
			next_st.fetch = 1'b1;
		end
		// One fetch per request falling edge, set wins
		if (fall && st.run)
			next_st.pend = 1'b1; // [RULE6]
		// Advance after the memory read
		if (st.fetch)
		begin
			next_st.addr = st.addr + ADDR_W'(1);
			next_st.cnt = st.cnt - CNT_W'(1);
			if (st.cnt == CNT_W'(1))
			begin
				next_st.run = 1'b0; // [RULE10]
				next_st.pend = 1'b0;
				next_st.done = 1'b1;
			end
		end
		// Start at a page boundary, main plus overflow
		if (start)
		begin
			next_st.run = 1'b1;
			next_st.addr = {start_page, `DPW_PAGE_ZERO}; // [RULE15]
			next_st.cnt = {(SIZE_W+1)'(size_pages) + (SIZE_W+1)'(ovf_pages),
				8'h00}; // [RULE16]
			next_st.pend = 1'b0;
		end
		else if (rewind && st.run)
		begin
			next_st.addr = rewind_addr;
			next_st.cnt = rewind_count;
		end
		// Edge bytes drive one output, no-op keeps all
		if (accept && hit && sel != `DPW_NOOP_IDX) // [RULE4]
			next_st.hc[sel] = level; // [RULE3] [RULE21]
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	// Buffer between memory fetch and port
	dpw_buf2 #(.WIDTH(24)) u_buf
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_valid(st.fetch),
		.in_ready(buf_ready),
		.in_data({dest_addr, mem_data}),
		.out_valid(buf_valid),
		.out_ready(!port_hold),
		.out_data(buf_data)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_edge_byte;
		accept && hit && sel != `DPW_NOOP_IDX;
	endsequence

	property p_edge_level;
		@(posedge ref_clk) disable iff (sys_rst)
		s_edge_byte |=> hc_out[$past(sel)] == $past(level);
	endproperty
	a_edge_level: assert property (p_edge_level) // [RULE2]
		else $error("edge byte did not set output level");

	property p_noop;
		@(posedge ref_clk) disable iff (sys_rst)
		accept && sel == `DPW_NOOP_IDX |=> $stable(hc_out);
	endproperty
	a_noop: assert property (p_noop) // [RULE4]
		else $error("no-op byte changed an output");

	property p_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!(accept && hit) |=> $stable(hc_out);
	endproperty
	a_hold: assert property (p_hold) // [RULE21]
		else $error("output moved without an edge byte");

	property p_one_bit;
		@(posedge ref_clk) disable iff (sys_rst)
		s_edge_byte |=> $countones(hc_out ^ $past(hc_out)) <= 1;
	endproperty
	a_one_bit: assert property (p_one_bit) // [RULE1]
		else $error("edge byte changed more than one output");

	property p_stop;
		@(posedge ref_clk) disable iff (sys_rst)
		st.cnt == '0 && !start |=> !mem_rd;
	endproperty
	a_stop: assert property (p_stop) // [RULE10]
		else $error("fetch with exhausted count");

	sequence s_last_fetch;
		mem_rd && st.cnt == CNT_W'(1) && !start && !rewind;
	endsequence

	property p_done;
		@(posedge ref_clk) disable iff (sys_rst)
		s_last_fetch |=> done && !running ##1 !done;
	endproperty
	a_done: assert property (p_done) // [RULE10]
		else $error("count end did not stop transfer");

	property p_single;
		@(posedge ref_clk) disable iff (sys_rst)
		mem_rd |=> !mem_rd;
	endproperty
	a_single: assert property (p_single) // [RULE6]
		else $error("two fetches back to back");

	property p_need_edge;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(mem_rd) |-> $past(st.pend);
	endproperty
	a_need_edge: assert property (p_need_edge) // [RULE6]
		else $error("fetch without request edge");

	property p_page;
		@(posedge ref_clk) disable iff (sys_rst)
		start |=> mem_addr[7:0] == `DPW_PAGE_ZERO && running;
	endproperty
	a_page: assert property (p_page) // [RULE15]
		else $error("start not on page boundary");

	property p_sclk;
		@(posedge ref_clk) disable iff (sys_rst)
		$changed(serial_port_clock_out) |-> $past(wrap);
	endproperty
	a_sclk: assert property (p_sclk) // [RULE14]
		else $error("serial clock toggled off schedule");
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bench for the pattern output block
// ----------------------------------------
module tb_top
	import dpw_pkg::*;
;
	logic ref_clk = 0, sys_rst = 1, req = 1, start = 0, rewind = 0;
	logic port_hold = 0, req_loop = 0, sclk, running, done, mem_rd;
	dpw_rate_t rate_sel = DPW_X4;
	logic [15:0] dest_addr = 16'h4100;
	logic [19:0] rewind_addr = 20'h00000, mem_addr;
	logic [16:0] rewind_count = 17'h00000, remain;
	logic [7:0] mem_data;
	logic [6:0] hc_out, exp_out = 7'h00;
	int mismatches = 0, n_tests = 0, n_done = 0, n_rd = 0;

	dpw_top #(.PAGE_W(12), .SIZE_W(8)) i_dpw_top (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .rate_sel(rate_sel),
		.serial_port_clock_out(sclk),
		.dma_channel_request(req_loop ? sclk : req),
		.start(start), .start_page(12'h001), .size_pages(8'h01),
		.ovf_pages(8'h01), .dest_addr(dest_addr), .rewind(rewind),
		.rewind_addr(rewind_addr), .rewind_count(rewind_count),
		.running(running), .remain(remain), .done(done),
		.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data),
		.port_hold(port_hold), .hc_out(hc_out));
	dpw_mem_model i_dpw_mem_model (.ref_clk(ref_clk), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_data(mem_data));

	// Clock
	initial forever #10 ref_clk = ~ref_clk;
	// Pulse counters
	always @(posedge ref_clk)
	begin
		if (done === 1'b1) n_done++;
		if (mem_rd === 1'b1) n_rd++;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [19:0] e,
		input logic [19:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s exp %0h got %0h", nm, e, g);
		end
	endtask
	// Falling request edges, then settle
	task automatic fire(input int n);
		repeat (n)
		begin
			@(posedge ref_clk) req <= 1'b0;
			repeat (12) @(posedge ref_clk);
			req <= 1'b1;
			repeat (6) @(posedge ref_clk);
		end
		@(negedge ref_clk);
	endtask
	// Expected effect of one byte
	function automatic void apply(input logic [7:0] b);
		if (b[3:1] != 3'h7) exp_out[b[3:1]] = b[0];
	endfunction
	// Pattern byte: out0 on at 0, off at off0; out1 on at 1, off at 13
	function automatic logic [7:0] pat(input int i, input int off0);
		int k;
		k = i % 16;
		pat = 8'h0E;
		if (k == 0) pat = 8'h01;
		if (k == 1) pat = 8'h03;
		if (k == off0) pat = 8'h00;
		if (k == 13) pat = 8'h02;
	endfunction
	// Cycles until output 0 reaches a level
	task automatic wait_out0(input logic lvl, output int n);
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (hc_out[0] !== lvl && n < 20000);
	endtask
	task automatic complete_run;
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_rate;
		int c;
		int r;
		int e;
		logic p;
		dpw_rate_t sel [3] = '{DPW_X2, DPW_X4, DPW_X8};
		for (int k = 0; k < 3; k++)
		begin
			@(posedge ref_clk) rate_sel <= sel[k];
			c = 0;
			r = 0;
			p = 1'b1;
			e = 200000000 / (19200 * (2 << k));
			while (r < 5 && c < 20000)
			begin
				@(negedge ref_clk);
				if (r > 0) c++;
				if (sclk === 1'b1 && p === 1'b0) r++;
				p = sclk;
			end
			chk("sclk_4_periods", 1, 20'(c >= e - 2 && c <= e + 2));
		end
	endtask
	task automatic t_start;
		@(posedge ref_clk) start <= 1'b1;
		@(posedge ref_clk) start <= 1'b0;
		@(negedge ref_clk);
		chk("running", 1, 20'(running));
		chk("remain", 20'd512, 20'(remain));
		chk("base", 20'h00100, mem_addr);
	endtask
	task automatic t_codes;
		logic [7:0] b;
		for (int i = 0; i < 16; i++)
		begin
			b = (i < 7) ? 8'(2 * i + 1) : (i == 7) ? 8'h0E :
				(i == 8) ? 8'hF0 : 8'(2 * (i - 8));
			i_dpw_mem_model.mem[256 + i] = b;
			apply(b);
			fire(1);
			chk("hc_out", 20'(exp_out), 20'(hc_out));
		end
	endtask
	task automatic t_hold;
		i_dpw_mem_model.mem[272] = 8'h05;
		i_dpw_mem_model.mem[273] = 8'h07;
		i_dpw_mem_model.mem[274] = 8'h04;
		@(posedge ref_clk) port_hold <= 1'b1;
		fire(3);
		chk("held", 20'h0, 20'(hc_out));
		@(posedge ref_clk) port_hold <= 1'b0;
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("released", 20'h08, 20'(hc_out));
		chk("remain", 20'd493, 20'(remain));
	endtask
	task automatic t_dest;
		i_dpw_mem_model.mem[275] = 8'h09;
		@(posedge ref_clk) dest_addr <= 16'h4101;
		fire(1);
		chk("foreign", 20'h08, 20'(hc_out));
		@(posedge ref_clk) dest_addr <= 16'h4100;
	endtask
	task automatic t_end;
		int n0;
		i_dpw_mem_model.mem[320] = 8'h0D;
		i_dpw_mem_model.mem[321] = 8'h01;
		@(posedge ref_clk) rewind <= 1'b1;
		rewind_addr <= 20'h00140;
		rewind_count <= 17'd2;
		@(posedge ref_clk) rewind <= 1'b0;
		@(negedge ref_clk);
		chk("rw_addr", 20'h00140, mem_addr);
		chk("rw_count", 20'd2, 20'(remain));
		fire(2);
		chk("tail", 20'h49, 20'(hc_out));
		chk("done", 1, 20'(n_done));
		chk("stopped", 0, 20'(running));
		n0 = n_rd;
		fire(1);
		chk("no_fetch", 20'(n0), 20'(n_rd));
		chk("kept", 20'h49, 20'(hc_out));
	endtask
	// Two channels, eight steps, request fed by the serial clock
	task automatic t_pwm;
		int e;
		int t1;
		int t2;
		e = 50000000 / (76800 / (2 * 8));
		for (int i = 0; i < 64; i++)
		begin
			i_dpw_mem_model.mem[512 + i] = pat(i, 6);
			i_dpw_mem_model.mem[1024 + i] = pat(i, 4);
		end
		@(posedge ref_clk) rate_sel <= DPW_X4;
		start <= 1'b1;
		@(posedge ref_clk) start <= 1'b0;
		rewind <= 1'b1;
		rewind_addr <= 20'h00200;
		rewind_count <= 17'd64;
		@(posedge ref_clk) rewind <= 1'b0;
		while (sclk !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk) req_loop <= 1'b1;
		wait_out0(1'b0, t1);
		wait_out0(1'b1, t1);
		wait_out0(1'b0, t2);
		chk("pwm_period", 1, 20'(t1 + t2 >= e - 2 && t1 + t2 <= e + 2));
		chk("duty_a", 1, 20'(t2 >= e * 3 / 8 - 2 && t2 <= e * 3 / 8 + 2));
		chk("phase_addr", 20'h00217, mem_addr);
		chk("refresh_margin", 1, 20'(remain >= 17'd32));
		@(posedge ref_clk) rewind <= 1'b1;
		rewind_addr <= 20'h00400 | 20'(mem_addr[3:0]);
		rewind_count <= 17'd64 - 17'(mem_addr[3:0]);
		@(posedge ref_clk) rewind <= 1'b0;
		@(negedge ref_clk);
		chk("sw_addr", 20'h00407, mem_addr);
		chk("sw_count", 20'd57, 20'(remain));
		wait_out0(1'b1, t1);
		wait_out0(1'b0, t2);
		chk("duty_b", 1, 20'(t2 >= e / 4 - 2 && t2 <= e / 4 + 2));
		@(posedge ref_clk) req_loop <= 1'b0;
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk("rst_out", 20'h0, 20'(hc_out));
		t_rate;
		t_start;
		t_codes;
		t_hold;
		t_dest;
		t_end;
		t_pwm;
		complete_run;
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		mismatches++;
		complete_run;
	end
endmodule
`default_nettype wire
